/* File: common/sew_params.svh */
/*
  Constants of the SDRAM ECC wrapper: register indexes, control and status
  bit positions, reset values and code geometry.
  Assumes it is included once per compile unit, ahead of the package.
*/
`ifndef SEW_PARAMS_SVH
`define SEW_PARAMS_SVH

// code geometry
`define SEW_DW        64
`define SEW_CW        72
`define SEW_PW        8
`define SEW_BYTE      8
`define SEW_WORD      32
`define SEW_HAM_BITS  7

// register indexes on the control port
`define SEW_REG_CTRL  4'h0
`define SEW_REG_SBTHR 4'h1
`define SEW_REG_DBTHR 4'h2
`define SEW_REG_SBCNT 4'h3
`define SEW_REG_DBCNT 4'h4
`define SEW_REG_SBADR 4'h5
`define SEW_REG_DBADR 4'h6
`define SEW_REG_SBDAT 4'h7
`define SEW_REG_STAT  4'h8
`define SEW_REG_SYND  4'h9

// reset values
`define SEW_CTRL_RST  32'h0000000F
`define SEW_THR_RST   32'h00000001

// control word bits
`define SEW_C_CORR    0
`define SEW_C_SBIE    1
`define SEW_C_DBIE    2
`define SEW_C_CNTEN   3
`define SEW_C_FRC1    8
`define SEW_C_FRC2    9
`define SEW_C_FIRST   10
`define SEW_C_CLEAR   11

// status bits, write 1 to clear
`define SEW_S_SBE     0
`define SEW_S_DBE     1
`define SEW_S_SBTH    2
`define SEW_S_DBTH    3
`define SEW_S_RMWF    4
`define SEW_S_W       5

// local burst sizes
`define SEW_SIZE1     2'h1
`define SEW_SIZE2     2'h2

`endif

/* File: common/sew_pkg.sv */
/*
  Types and code functions of the SDRAM ECC wrapper: the per-slice decode
  result, the sequencer states and the (72,64) SEC-DED encode and decode.
  Assumes sew_params.svh is reachable on the include path.
*/
`include "sew_params.svh"

package sew_pkg;

  typedef struct packed {
    logic [`SEW_DW-1:0] data;
    logic [`SEW_PW-1:0] synd;
    logic               sbe;
    logic               dbe;
  } sew_dec_t;

  typedef enum logic {st_idle, st_rmw} sew_state_t;

  // hamming positions 3..71 that are not powers of two carry the data bits
  function automatic logic [`SEW_PW-1:0] sew_chk(input logic [`SEW_DW-1:0] d);
    logic [`SEW_PW-1:0] c;
    int                 j;
    c = '0;
    j = 0;
    for (int p = 3; p < `SEW_CW; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        for (int k = 0; k < `SEW_HAM_BITS; k++)
          if (p[k])
            c[k] = c[k] ^ d[j];
        j++;
      end
    end
    c[`SEW_PW-1] = ^d ^ ^c[`SEW_HAM_BITS-1:0];
    return c;
  endfunction

  function automatic sew_dec_t sew_dec(input logic [`SEW_CW-1:0] cw);
    sew_dec_t                r;
    logic [`SEW_PW-1:0]      c;
    logic [`SEW_HAM_BITS-1:0] s;
    logic                    ov;
    int                      j;
    c = sew_chk(cw[`SEW_DW-1:0]);
    s = c[`SEW_HAM_BITS-1:0] ^ cw[`SEW_DW+`SEW_HAM_BITS-1:`SEW_DW];
    ov = ^cw;
    r.data = cw[`SEW_DW-1:0];
    r.synd = {ov, s};
    r.sbe = ov;
    r.dbe = !ov && (s != '0);
    j = 0;
    for (int p = 3; p < `SEW_CW; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (ov && (s == p[`SEW_HAM_BITS-1:0]))
          r.data[j] = ~r.data[j];
        j++;
      end
    end
    return r;
  endfunction

endpackage

/* File: core/sew_wrapper.sv */
/*
  SDRAM ECC wrapper: SEC-DED encode/decode per 64-bit slice between local
  user logic and the memory controller, error counters, capture registers,
  read-modify-write for byte-masked writes, and a small control port.
  Assumes a memory controller that answers reads in order of issue and
  holds mem_waitreq high while it cannot take a command.
*/
// Local design decisions: the register addresses and strobed register access.
`include "sew_params.svh"

module sew_wrapper
  import sew_pkg::*;
#(
  parameter int N_SLICES  = 1,
  parameter int ADDR_W    = 24,
  parameter bit FULL_RATE = 1'b1,
  parameter int RD_LAT    = 1,
  parameter int RQ_DEPTH  = 4
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  // local user side
  input  wire logic                          loc_read,
  input  wire logic                          loc_write,
  input  wire logic [ADDR_W-1:0]             loc_addr,
  input  wire logic [1:0]                    loc_size,
  input  wire logic [N_SLICES*`SEW_DW-1:0]   loc_wdata,
  input  wire logic [N_SLICES*`SEW_PW-1:0]   loc_be,
  output logic                               loc_ready,
  output logic [N_SLICES*`SEW_DW-1:0]        loc_rdata,
  output logic                               loc_rvalid,
  output logic                               loc_rerr,
  // memory controller side
  output logic                               mem_read,
  output logic                               mem_write,
  output logic [ADDR_W-1:0]                  mem_addr,
  output logic [1:0]                         mem_size,
  output logic [N_SLICES*`SEW_CW-1:0]        mem_wdata,
  input  wire logic                          mem_waitreq,
  input  wire logic [N_SLICES*`SEW_CW-1:0]   mem_rdata,
  input  wire logic                          mem_rvalid,
  // control port
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [`SEW_WORD-1:0]          reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [`SEW_WORD-1:0]               reg_rdata,
  // interrupt
  output logic                               irq
);

  localparam int DW    = N_SLICES * `SEW_DW;
  localparam int CW    = N_SLICES * `SEW_CW;
  localparam int BW    = N_SLICES * `SEW_PW;
  localparam int QAW   = (RQ_DEPTH > 1) ? $clog2(RQ_DEPTH) : 1;
  localparam int SD_D  = 2 * N_SLICES;
  localparam int SDAW  = $clog2(SD_D);
  localparam int SYN_N = (N_SLICES < 4) ? N_SLICES : 4;

  // sequencer and command state
  sew_state_t             state, next_state;
  logic                   c_rd, next_c_rd;
  logic                   c_wr, next_c_wr;
  logic [ADDR_W-1:0]      c_addr, next_c_addr;
  logic [1:0]             c_size, next_c_size;
  logic [CW-1:0]          c_wdata, next_c_wdata;
  logic                   rdy, next_rdy;
  logic                   wb, next_wb;
  logic [ADDR_W-1:0]      pw_addr, next_pw_addr;
  logic [DW-1:0]          pw_data, next_pw_data;
  logic [BW-1:0]          pw_be, next_pw_be;
  logic [1:0]             rb, next_rb;
  logic [ADDR_W-1:0]      q_addr [RQ_DEPTH];
  logic [ADDR_W-1:0]      next_q_addr [RQ_DEPTH];
  logic [1:0]             q_size [RQ_DEPTH];
  logic [1:0]             next_q_size [RQ_DEPTH];
  logic                   q_rmw [RQ_DEPTH];
  logic                   next_q_rmw [RQ_DEPTH];
  logic [QAW-1:0]         q_wp, next_q_wp, q_rp, next_q_rp;
  logic [QAW:0]           q_cnt, next_q_cnt;

  // read pipe
  logic                   p_v [RD_LAT];
  logic                   next_p_v [RD_LAT];
  logic [DW-1:0]          p_d [RD_LAT];
  logic [DW-1:0]          next_p_d [RD_LAT];
  logic                   p_e [RD_LAT];
  logic                   next_p_e [RD_LAT];

  // register file
  logic [`SEW_WORD-1:0]   ctrl, next_ctrl;
  logic [`SEW_WORD-1:0]   sb_thr, next_sb_thr, db_thr, next_db_thr;
  logic [`SEW_WORD-1:0]   sb_cnt, next_sb_cnt, db_cnt, next_db_cnt;
  logic [`SEW_WORD-1:0]   sb_adr, next_sb_adr, db_adr, next_db_adr;
  logic [`SEW_WORD-1:0]   synd, next_synd;
  logic [`SEW_S_W-1:0]    stat, next_stat;
  logic                   sb_cap, next_sb_cap, db_cap, next_db_cap;
  logic [`SEW_WORD-1:0]   sdat [SD_D];
  logic [`SEW_WORD-1:0]   next_sdat [SD_D];
  logic [SDAW-1:0]        sd_ptr, next_sd_ptr;
  logic [`SEW_WORD-1:0]   rdat, next_rdat;
  logic                   irq_q, next_irq;

  // slice datapath
  sew_dec_t               dec [N_SLICES];
  logic [DW-1:0]          rd_raw, rd_fix, merged, enc_in;
  logic [CW-1:0]          enc_cw;
  logic [N_SLICES-1:0]    s_sbe, s_dbe;
  logic [`SEW_PW-1:0]     frc;
  logic                   acc, partial, ret_last, ret_rmw, ret_loc;
  logic [ADDR_W-1:0]      beat_addr, err_addr;
  logic [1:0]             eff_size;

  // a forced double flips two check bits so the decoder sees an even error
  assign frc = {6'h00, ctrl[`SEW_C_FRC2], ctrl[`SEW_C_FRC1] | ctrl[`SEW_C_FRC2]};
  assign enc_in = (state == st_rmw) ? merged : loc_wdata;

  for (genvar i = 0; i < N_SLICES; i++)
  begin : g_slice
    assign dec[i] = sew_dec(mem_rdata[i*`SEW_CW +: `SEW_CW]);
    assign rd_raw[i*`SEW_DW +: `SEW_DW] = mem_rdata[i*`SEW_CW +: `SEW_DW];
    assign rd_fix[i*`SEW_DW +: `SEW_DW] = ctrl[`SEW_C_CORR] ? dec[i].data
                                          : rd_raw[i*`SEW_DW +: `SEW_DW];
    assign s_sbe[i] = mem_rvalid & dec[i].sbe;
    assign s_dbe[i] = mem_rvalid & dec[i].dbe;
    assign enc_cw[i*`SEW_CW +: `SEW_CW] = {sew_chk(enc_in[i*`SEW_DW +: `SEW_DW]) ^ frc,
                                           enc_in[i*`SEW_DW +: `SEW_DW]};
  end

  for (genvar b = 0; b < BW; b++)
  begin : g_merge
    assign merged[b*`SEW_BYTE +: `SEW_BYTE] = pw_be[b] ? pw_data[b*`SEW_BYTE +: `SEW_BYTE]
                                              : rd_fix[b*`SEW_BYTE +: `SEW_BYTE];
  end

  assign acc       = rdy & (loc_read | loc_write);
  assign partial   = loc_write & ~(&loc_be);
  assign eff_size  = (FULL_RATE && loc_size == `SEW_SIZE2) ? `SEW_SIZE2 : `SEW_SIZE1;
  assign beat_addr = loc_addr + ADDR_W'(wb);
  assign ret_last  = mem_rvalid && (rb == q_size[q_rp] - `SEW_SIZE1);
  assign ret_rmw   = mem_rvalid & q_rmw[q_rp];
  assign ret_loc   = mem_rvalid & ~q_rmw[q_rp];
  assign err_addr  = q_addr[q_rp] + ADDR_W'(rb);

  // sequencer: commands, partial write, read tag queue
  always_comb
  begin
    next_state   = state;
    next_c_rd    = c_rd;
    next_c_wr    = c_wr;
    next_c_addr  = c_addr;
    next_c_size  = c_size;
    next_c_wdata = c_wdata;
    next_wb      = wb;
    next_pw_addr = pw_addr;
    next_pw_data = pw_data;
    next_pw_be   = pw_be;
    next_q_addr  = q_addr;
    next_q_size  = q_size;
    next_q_rmw   = q_rmw;
    next_q_wp    = q_wp;
    next_q_rp    = q_rp;
    next_q_cnt   = q_cnt;
    next_rb      = mem_rvalid ? rb + 2'h1 : rb;
    if ((c_rd | c_wr) && !mem_waitreq)
    begin
      next_c_rd = 1'b0;
      next_c_wr = 1'b0;
    end
    if (ret_last)
    begin
      next_rb    = 2'h0;
      next_q_rp  = q_rp + QAW'(1);
      next_q_cnt = next_q_cnt - (QAW+1)'(1);
    end
    if (acc)
    begin
      next_c_size = `SEW_SIZE1;
      next_c_addr = beat_addr;
      if (loc_read)
      begin
        next_c_rd   = 1'b1;
        next_c_addr = loc_addr;
        next_c_size = eff_size;
        next_wb     = 1'b0;
      end
      else
      begin
        // bursts go out beat by beat so a masked beat can be patched alone
        next_wb = (eff_size == `SEW_SIZE2) && !wb;
        if (partial)
        begin
          next_c_rd    = 1'b1;
          next_state   = st_rmw;
          next_pw_addr = beat_addr;
          next_pw_data = loc_wdata;
          next_pw_be   = loc_be;
        end
        else
        begin
          next_c_wr    = 1'b1;
          next_c_wdata = enc_cw;
        end
      end
      if (loc_read || partial)
      begin
        next_q_addr[q_wp] = next_c_addr;
        next_q_size[q_wp] = next_c_size;
        next_q_rmw[q_wp]  = partial;
        next_q_wp         = q_wp + QAW'(1);
        next_q_cnt        = next_q_cnt + (QAW+1)'(1);
      end
    end
    if (ret_rmw)
    begin
      next_state = st_idle;
      if (!(|s_dbe))
      begin
        next_c_wr    = 1'b1;
        next_c_addr  = pw_addr;
        next_c_size  = `SEW_SIZE1;
        next_c_wdata = enc_cw;
      end
    end
    // one command at a time; a stalled controller stalls the local side
    next_rdy = (next_state == st_idle) && !next_c_rd && !next_c_wr
               && (next_q_cnt < (QAW+1)'(RQ_DEPTH));
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state   <= st_idle;
      c_rd    <= 1'b0;
      c_wr    <= 1'b0;
      c_addr  <= '0;
      c_size  <= `SEW_SIZE1;
      c_wdata <= '0;
      rdy     <= 1'b1;
      wb      <= 1'b0;
      pw_addr <= '0;
      pw_data <= '0;
      pw_be   <= '0;
      rb      <= 2'h0;
      q_wp    <= '0;
      q_rp    <= '0;
      q_cnt   <= '0;
      for (int k = 0; k < RQ_DEPTH; k++)
      begin
        q_addr[k] <= '0;
        q_size[k] <= `SEW_SIZE1;
        q_rmw[k]  <= 1'b0;
      end
    end
    else
    begin
      state   <= next_state;
      c_rd    <= next_c_rd;
      c_wr    <= next_c_wr;
      c_addr  <= next_c_addr;
      c_size  <= next_c_size;
      c_wdata <= next_c_wdata;
      rdy     <= next_rdy;
      wb      <= next_wb;
      pw_addr <= next_pw_addr;
      pw_data <= next_pw_data;
      pw_be   <= next_pw_be;
      rb      <= next_rb;
      q_wp    <= next_q_wp;
      q_rp    <= next_q_rp;
      q_cnt   <= next_q_cnt;
      q_addr  <= next_q_addr;
      q_size  <= next_q_size;
      q_rmw   <= next_q_rmw;
    end
  end

  // read return pipe
  always_comb
  begin
    next_p_v[0] = ret_loc;
    next_p_d[0] = rd_fix;
    // read-back errors of a partial write stay internal, flag only local beats
    next_p_e[0] = ret_loc & (|s_dbe);
    for (int k = 1; k < RD_LAT; k++)
    begin
      next_p_v[k] = p_v[k-1];
      next_p_d[k] = p_d[k-1];
      next_p_e[k] = p_e[k-1];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < RD_LAT; k++)
      begin
        p_v[k] <= 1'b0;
        p_d[k] <= '0;
        p_e[k] <= 1'b0;
      end
    end
    else
    begin
      p_v <= next_p_v;
      p_d <= next_p_d;
      p_e <= next_p_e;
    end
  end

  // registers, counters, capture, interrupt
  always_comb
  begin
    int n_sb;
    int n_db;
    logic clr;
    logic [`SEW_S_W-1:0] set;
    n_sb = 0;
    n_db = 0;
    set  = '0;
    clr  = reg_wr && (reg_addr == `SEW_REG_CTRL) && reg_wdata[`SEW_C_CLEAR];
    for (int i = 0; i < N_SLICES; i++)
    begin
      n_sb = n_sb + int'(s_sbe[i]);
      n_db = n_db + int'(s_dbe[i]);
    end
    next_ctrl   = ctrl;
    next_sb_thr = sb_thr;
    next_db_thr = db_thr;
    next_sb_cnt = sb_cnt;
    next_db_cnt = db_cnt;
    next_sb_adr = sb_adr;
    next_db_adr = db_adr;
    next_synd   = synd;
    next_sb_cap = sb_cap;
    next_db_cap = db_cap;
    next_sdat   = sdat;
    next_sd_ptr = sd_ptr;
    next_stat   = stat;
    if (reg_wr)
    begin
      case (reg_addr)
        `SEW_REG_CTRL:  next_ctrl = reg_wdata & ~(`SEW_WORD'(1) << `SEW_C_CLEAR);
        `SEW_REG_SBTHR: next_sb_thr = reg_wdata;
        `SEW_REG_DBTHR: next_db_thr = reg_wdata;
        `SEW_REG_STAT:  next_stat = stat & ~reg_wdata[`SEW_S_W-1:0];
        default:        next_stat = next_stat;
      endcase
    end
    if (reg_rd && reg_addr == `SEW_REG_SBDAT)
      next_sd_ptr = (sd_ptr == SDAW'(SD_D - 1)) ? '0 : sd_ptr + SDAW'(1);
    if (clr)
    begin
      next_sb_cnt = '0;
      next_db_cnt = '0;
      next_sb_adr = '0;
      next_db_adr = '0;
      next_synd   = '0;
      next_sb_cap = 1'b0;
      next_db_cap = 1'b0;
      next_sd_ptr = '0;
      for (int k = 0; k < SD_D; k++)
        next_sdat[k] = '0;
    end
    // events land after software writes so a same-cycle set beats a clear
    if (n_sb > 0)
    begin
      set[`SEW_S_SBE] = 1'b1;
      if (ctrl[`SEW_C_CNTEN])
      begin
        next_sb_cnt = next_sb_cnt + `SEW_WORD'(n_sb);
        set[`SEW_S_SBTH] = (next_sb_cnt == sb_thr);
      end
      if (!ctrl[`SEW_C_FIRST] || !next_sb_cap)
      begin
        next_sb_cap = 1'b1;
        next_sb_adr = `SEW_WORD'(err_addr);
        for (int k = 0; k < SD_D; k++)
          next_sdat[k] = rd_raw[k*`SEW_WORD +: `SEW_WORD];
        for (int i = 0; i < SYN_N; i++)
          next_synd[i*`SEW_PW +: `SEW_PW] = dec[i].synd;
      end
    end
    if (n_db > 0)
    begin
      set[`SEW_S_DBE]  = 1'b1;
      set[`SEW_S_RMWF] = ret_rmw;
      if (ctrl[`SEW_C_CNTEN])
      begin
        next_db_cnt = next_db_cnt + `SEW_WORD'(n_db);
        set[`SEW_S_DBTH] = (next_db_cnt == db_thr);
      end
      if (!ctrl[`SEW_C_FIRST] || !next_db_cap)
      begin
        next_db_cap = 1'b1;
        next_db_adr = `SEW_WORD'(err_addr);
        for (int i = 0; i < SYN_N; i++)
          next_synd[i*`SEW_PW +: `SEW_PW] = dec[i].synd;
      end
    end
    next_stat = next_stat | set;
    next_irq = (ctrl[`SEW_C_SBIE] && (next_stat[`SEW_S_SBE] || next_stat[`SEW_S_SBTH]))
               || (ctrl[`SEW_C_DBIE] && (next_stat[`SEW_S_DBE] || next_stat[`SEW_S_DBTH]
               || next_stat[`SEW_S_RMWF]));
    next_rdat = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `SEW_REG_CTRL:  next_rdat = ctrl;
        `SEW_REG_SBTHR: next_rdat = sb_thr;
        `SEW_REG_DBTHR: next_rdat = db_thr;
        `SEW_REG_SBCNT: next_rdat = sb_cnt;
        `SEW_REG_DBCNT: next_rdat = db_cnt;
        `SEW_REG_SBADR: next_rdat = sb_adr;
        `SEW_REG_DBADR: next_rdat = db_adr;
        `SEW_REG_SBDAT: next_rdat = sdat[sd_ptr];
        `SEW_REG_STAT:  next_rdat = `SEW_WORD'(stat);
        `SEW_REG_SYND:  next_rdat = synd;
        default:        next_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl   <= `SEW_CTRL_RST;
      sb_thr <= `SEW_THR_RST;
      db_thr <= `SEW_THR_RST;
      sb_cnt <= '0;
      db_cnt <= '0;
      sb_adr <= '0;
      db_adr <= '0;
      synd   <= '0;
      stat   <= '0;
      sb_cap <= 1'b0;
      db_cap <= 1'b0;
      sd_ptr <= '0;
      rdat   <= '0;
      irq_q  <= 1'b0;
      for (int k = 0; k < SD_D; k++)
        sdat[k] <= '0;
    end
    else
    begin
      ctrl   <= next_ctrl;
      sb_thr <= next_sb_thr;
      db_thr <= next_db_thr;
      sb_cnt <= next_sb_cnt;
      db_cnt <= next_db_cnt;
      sb_adr <= next_sb_adr;
      db_adr <= next_db_adr;
      synd   <= next_synd;
      stat   <= next_stat;
      sb_cap <= next_sb_cap;
      db_cap <= next_db_cap;
      sd_ptr <= next_sd_ptr;
      rdat   <= next_rdat;
      irq_q  <= next_irq;
      sdat   <= next_sdat;
    end
  end

  // outputs, all registered
  assign loc_ready  = rdy;
  assign loc_rvalid = p_v[RD_LAT-1];
  assign loc_rdata  = p_d[RD_LAT-1];
  assign loc_rerr   = p_e[RD_LAT-1];
  assign mem_read   = c_rd;
  assign mem_write  = c_wr;
  assign mem_addr   = c_addr;
  assign mem_size   = c_size;
  assign mem_wdata  = c_wdata;
  assign reg_rdata  = rdat;
  assign irq        = irq_q;

endmodule

/* File: testbench/sew_wrapper_props.sv */
/*
  Port checks of the ECC wrapper.
  Assumes one clock domain, bound to the wrapper from the bench.
*/
`include "sew_params.svh"

module sew_wrapper_props #(
  parameter int N_SLICES = 1,
  parameter int ADDR_W   = 24,
  parameter int RD_LAT   = 1
) (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        arst_n,
  // local side
  input wire logic                        loc_read,
  input wire logic                        loc_write,
  input wire logic [N_SLICES*`SEW_DW-1:0] loc_wdata,
  input wire logic [N_SLICES*`SEW_PW-1:0] loc_be,
  input wire logic                        loc_ready,
  input wire logic                        loc_rvalid,
  input wire logic                        loc_rerr,
  // memory side
  input wire logic                        mem_read,
  input wire logic                        mem_write,
  input wire logic [ADDR_W-1:0]           mem_addr,
  input wire logic [N_SLICES*`SEW_CW-1:0] mem_wdata,
  input wire logic                        mem_waitreq,
  input wire logic                        mem_rvalid,
  // control port
  input wire logic                        reg_rd,
  input wire logic [`SEW_WORD-1:0]        reg_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_take;
    loc_ready && (loc_read || loc_write);
  endsequence
  sequence s_full;
    loc_ready && loc_write && (&loc_be);
  endsequence
  sequence s_part;
    loc_ready && loc_write && !(&loc_be);
  endsequence

  AST_WR_LAT: assert property (s_full |=> mem_write && mem_wdata[63:0] == $past(loc_wdata[63:0]))
    else $error("full write not passed on in one cycle");
  AST_PART_RD: assert property (s_part |=> mem_read && !mem_write)
    else $error("partial write did not start a read");
  AST_STALL: assert property (s_take |=> !loc_ready)
    else $error("ready stayed high after a take");
  AST_HOLD: assert property (mem_write && mem_waitreq |=> mem_write && $stable(mem_wdata) && $stable(mem_addr))
    else $error("write command not held");
  AST_RD_LAT: assert property (loc_rvalid |-> $past(mem_rvalid, RD_LAT))
    else $error("read data without memory beat");
  AST_RERR: assert property (loc_rerr |-> loc_rvalid)
    else $error("error flag without data");
  AST_REG_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  AST_ONE_CMD: assert property (!(mem_read && mem_write))
    else $error("read and write together");
endmodule

/* File: testbench/sew_mem_model.sv */
/*
  Behavioural memory controller: 16 codewords, in-order reads.
  Assumes slow and flip come from the bench; flip corrupts returns.
*/
`include "sew_params.svh"

module sew_mem_model #(
  parameter int ADDR_W = 24
) (
  // clock and test controls
  input wire logic                clk_sys,
  input wire logic                slow,
  input wire logic [`SEW_CW-1:0]  flip,
  // command side
  input wire logic                mem_read,
  input wire logic                mem_write,
  input wire logic [ADDR_W-1:0]   mem_addr,
  input wire logic [1:0]          mem_size,
  input wire logic [`SEW_CW-1:0]  mem_wdata,
  output logic                    mem_waitreq,
  output logic [`SEW_CW-1:0]      mem_rdata,
  output logic                    mem_rvalid
);
  logic [`SEW_CW-1:0] store [16];
  logic [`SEW_CW-1:0] pend [$];

  initial {mem_waitreq, mem_rvalid, mem_rdata} = '0;

  // idle data toggles so a stale beat never looks valid
  always @(posedge clk_sys)
  begin
    mem_waitreq <= slow && ($urandom_range(1) == 1);
    if (!mem_waitreq && mem_write)
      store[mem_addr[3:0]] <= mem_wdata;
    if (!mem_waitreq && mem_read)
      for (int i = 0; i < int'(mem_size); i++)
        pend.push_back(store[mem_addr[3:0] + 4'(i)]);
    if (pend.size() > 0 && !(slow && $urandom_range(1) == 1))
      {mem_rvalid, mem_rdata} <= {1'h1, pend.pop_front() ^ flip};
    else
      {mem_rvalid, mem_rdata} <= {1'h0, ~mem_rdata};
  end
endmodule

/* File: testbench/tb.sv */
/*
  Self-checking bench of the ECC wrapper with a memory model.
  Assumes package, wrapper, model and checker compiled before it.
*/
`include "sew_params.svh"
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin mismatches++; $display("wrong value %s exp %0h got %0h", n, e, s); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'h0, arst_n = 1'h0, slow = 1'h0, rd_d = 1'h0;
  logic        loc_read = 1'h0, loc_write = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [23:0] loc_addr = '0, mem_addr;
  logic [1:0]  loc_size = 2'h1, mem_size;
  logic [63:0] loc_wdata = '0, loc_rdata, d;
  logic [7:0]  loc_be = 8'hFF;
  logic [3:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [71:0] flip = '0, mem_wdata, mem_rdata;
  logic        loc_ready, loc_rvalid, loc_rerr, mem_read, mem_write, mem_waitreq, mem_rvalid, irq;
  logic [63:0] shadow [16];
  logic [64:0] lq [$];
  logic [31:0] rq [$];
  int          mismatches = 0, total_checks = 0;

  always #20 clk_sys = ~clk_sys;

  sew_wrapper #(.N_SLICES(1), .ADDR_W(24), .FULL_RATE(1'h1), .RD_LAT(1), .RQ_DEPTH(4)) uut (.clk_sys, .arst_n,
    .loc_read, .loc_write, .loc_addr, .loc_size, .loc_wdata, .loc_be, .loc_ready, .loc_rdata, .loc_rvalid,
    .loc_rerr, .mem_read, .mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_waitreq, .mem_rdata, .mem_rvalid,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  sew_mem_model u_mem (.clk_sys, .slow, .flip, .mem_read, .mem_write, .mem_addr, .mem_size,
    .mem_wdata, .mem_waitreq, .mem_rdata, .mem_rvalid);

  // oldest note is compared with each answer
  always @(posedge clk_sys)
  begin
    rd_d <= reg_rd;
    if (rd_d === 1'h1) `CHK("reg_rdata", rq.pop_front(), reg_rdata)
    if (loc_rvalid === 1'h1) `CHK("loc_rdata", lq.pop_front(), {loc_rerr, loc_rdata})
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic hung();
    mismatches++;
    final_report();
  endtask

  task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] v);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge clk_sys);
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_op(1'h0, a, 32'h0);
  endtask

  // request held until the edge that sees ready high
  task automatic loc_op(input logic w, input logic [3:0] a, input logic [1:0] sz, input logic [63:0] v,
                        input logic [7:0] be);
    int n;
    n = 0;
    {loc_write, loc_read, loc_addr, loc_size, loc_wdata, loc_be} <= {w, !w, 20'h0, a, sz, v, be};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (loc_ready !== 1'h1 && n < 300);
    {loc_write, loc_read} <= 2'h0;
    @(posedge clk_sys);
    if (n >= 300)
      hung();
  endtask

  task automatic settle();
    int n;
    for (n = 0; n < 300 && (lq.size() > 0 || loc_ready !== 1'h1); n++)
      @(posedge clk_sys);
    if (n >= 300)
      hung();
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] v, input logic [7:0] be);
    for (int i = 0; i < 8; i++)
      if (be[i])
        shadow[a][i*8+:8] = v[i*8+:8];
    loc_op(1'h1, a, 2'h1, v, be);
    settle();
  endtask

  task automatic rd(input logic [3:0] a, input logic [1:0] sz, input logic e);
    for (int i = 0; i < sz; i++)
      lq.push_back({e, shadow[a + i] ^ (e ? flip[63:0] : 64'h0)});
    loc_op(1'h0, a, sz, 64'h0, 8'hFF);
    settle();
  endtask

  initial
  begin
    void'($urandom(58262));
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'h1;
    rr(`SEW_REG_CTRL, 32'h0000000F);
    rr(`SEW_REG_DBTHR, 32'h00000001);
    rr(4'hF, 32'h0);
    for (int a = 0; a < 4; a++)
      wr(a, {$urandom, $urandom}, 8'hFF);
    for (int a = 0; a < 4; a++)
      rd(a, 2'h1, 1'h0);
    flip <= 72'h20;
    rd(0, 2'h1, 1'h0);
    flip <= 72'h0;
    rr(`SEW_REG_SBCNT, 32'h1);
    rr(`SEW_REG_STAT, 32'h5);
    `CHK("irq", 1'h1, irq)
    reg_op(1'h1, `SEW_REG_STAT, 32'h1F);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'h0, irq)
    reg_op(1'h1, `SEW_REG_CTRL, 32'h9);
    // blocking so the note taken below already sees the flipped bits
    flip = 72'h220;
    rd(1, 2'h1, 1'h1);
    flip <= 72'h0;
    rr(`SEW_REG_DBCNT, 32'h1);
    `CHK("irq", 1'h0, irq)
    // memory stalls from here on
    slow <= 1'h1;
    flip <= 72'h10000000000;
    wr(2, {$urandom, $urandom}, 8'h0F);
    flip <= 72'h0;
    rr(`SEW_REG_SBCNT, 32'h2);
    rd(2, 2'h1, 1'h0);
    flip <= 72'h220;
    loc_op(1'h1, 3, 2'h1, {$urandom, $urandom}, 8'hF0);
    settle();
    flip <= 72'h0;
    rr(`SEW_REG_STAT, 32'h1B);
    rd(3, 2'h1, 1'h0);
    reg_op(1'h1, `SEW_REG_CTRL, 32'h109);
    wr(0, {$urandom, $urandom}, 8'hFF);
    reg_op(1'h1, `SEW_REG_CTRL, 32'h9);
    rd(0, 2'h1, 1'h0);
    rr(`SEW_REG_SBCNT, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      d = {$urandom, $urandom};
      shadow[4 + i] = d;
      loc_op(1'h1, 4, 2'h2, d, 8'hFF);
    end
    settle();
    rd(4, 2'h2, 1'h0);
    final_report();
  end
endmodule

bind sew_wrapper sew_wrapper_props #(.N_SLICES(N_SLICES), .ADDR_W(ADDR_W), .RD_LAT(RD_LAT)) u_props (
  .clk_sys, .arst_n, .loc_read, .loc_write, .loc_wdata, .loc_be, .loc_ready, .loc_rvalid, .loc_rerr,
  .mem_read, .mem_write, .mem_addr, .mem_wdata, .mem_waitreq, .mem_rvalid, .reg_rd, .reg_rdata);
